// *** common/ldsl_pkg.sv ***
// Constants, carriers and state types of the loop converter serial loader
package ldsl_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int NORM_W  = 16;
	localparam int SHIFT_W = 17;
	localparam int CNT_W   = 5;
	localparam int ACC_W   = 24;

	// Pulse residues up to this value select the normal range
	localparam logic [CNT_W-1:0] NORMAL_MAX = 5'h10;
	localparam logic [CNT_W-1:0] CNT_STEP   = 5'h01;
	localparam logic [CNT_W-1:0] CNT_RST    = 5'h00;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	// 4 mA expressed on the 17-bit alarm scale, where one step is the same current
	localparam logic [SHIFT_W-1:0] NORM_BASE = 17'h04000;
	localparam logic [SHIFT_W-1:0] WORD_RST  = 17'h00000;
	localparam logic [ACC_W-1:0]   FULL_FB   = 24'h020000;
	localparam logic [ACC_W-1:0]   ACC_RST   = 24'h000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LDSL_HALT = 2'h1,
		LDSL_RUN  = 2'h2
	} ldsl_run_t;

	typedef struct packed {
		logic [SHIFT_W-1:0] shreg;
		logic [CNT_W-1:0]   cnt;
	} ldsl_link_t;

	typedef struct packed {
		logic               alarm;
		logic [SHIFT_W-1:0] word;
		logic [SHIFT_W-1:0] level;
	} ldsl_setting_t;

	typedef struct packed {
		ldsl_run_t                run;
		logic                     lat_s1;
		logic                     lat_s2;
		logic                     lat_s3;
		logic                     ovl_s1;
		logic                     ovl_s2;
		ldsl_link_t               lkw_s1;
		ldsl_link_t               lkw_s2;
		logic [CNT_W-1:0]         base;
		ldsl_setting_t            setting;
		logic                     latch_pulse;
		logic signed [ACC_W-1:0]  int1;
		logic signed [ACC_W-1:0]  int2;
		logic                     mod_bit;
	} ldsl_core_t;

endpackage : ldsl_pkg

// *** verilog/ldsl_loader.sv ***
// Serial loader, converter latch and modulator of the loop converter
//
// Summary of operation
// - Shift data on serial clock rise, MSB first
// - Latch rise copies shift register into latch
// - Count serial clock pulses between latch strobes
// - Residue 0-16 mod 32 normal, else alarm
// - Normal mode moves lower 16 bits
// - Normal code straight binary, 4 to 20 mA
// - Shift register holds at least 17 bits
// - Long writes keep only last 17 bits
// - Seventeenth edge before latch gives alarm MSB
// - Alarm mode moves 17 bits, 0 to 32 mA
// - Reference overload clears latch, stops modulator, oscillator
// - Latch value drives second order modulator
`timescale 1ns/100ps
`default_nettype none

module ldsl_loader #(
	parameter int NORM_W  = ldsl_pkg::NORM_W,
	parameter int SHIFT_W = ldsl_pkg::SHIFT_W
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   serial_clk,
	input  wire logic                   serial_data,
	input  wire logic                   latch_strobe,
	input  wire logic                   ref_overload,
	output var  ldsl_pkg::ldsl_setting_t setting,
	output logic                        latch_pulse,
	output logic                        mod_bit,
	output logic                        mod_enable,
	output logic                        osc_run
);

	localparam int SW = ldsl_pkg::SHIFT_W;
	localparam int NW = ldsl_pkg::NORM_W;
	localparam int CW = ldsl_pkg::CNT_W;
	localparam int AW = ldsl_pkg::ACC_W;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (NORM_W != NW || SHIFT_W != SW || SHIFT_W < NORM_W + 1) begin : g_bad_width
		$error("ldsl_loader: widths must match the package and leave one alarm bit");
	end

	// ----------------------------------------------------------------
	// Link domain: shift register and pulse counter
	// ----------------------------------------------------------------
	// The counter clears only at reset: the core remembers its value at each
	// latch rise, so no edge of a stopped serial clock is needed.
	ldsl_pkg::ldsl_link_t lk;
	ldsl_pkg::ldsl_link_t next_lk;

	always_comb begin
		next_lk = lk;
		next_lk.shreg = {lk.shreg[SW-2:0], serial_data};
		next_lk.cnt = lk.cnt + ldsl_pkg::CNT_STEP;
	end

	always_ff @(posedge serial_clk or negedge rstn) begin
		if (!rstn) begin
			lk <= '{shreg: ldsl_pkg::WORD_RST, cnt: ldsl_pkg::CNT_RST};
		end else begin
			lk <= next_lk;
		end
	end

	// ----------------------------------------------------------------
	// Core domain: crossing, latch, modulator
	// ----------------------------------------------------------------
	ldsl_pkg::ldsl_core_t core;
	ldsl_pkg::ldsl_core_t next_core;
	logic                 rise;
	logic [CW-1:0]        pulses;
	logic                 take;

	always_comb begin
		logic signed [AW-1:0] x;
		logic signed [AW-1:0] fb;
		logic signed [AW-1:0] i1n;
		logic signed [AW-1:0] i2n;
		x         = $signed({{(AW-SW){1'h0}}, core.setting.level});
		fb        = core.mod_bit ? $signed(ldsl_pkg::FULL_FB) : $signed(ldsl_pkg::ACC_RST);
		i1n       = core.int1 + ((x - fb) >>> 1);
		i2n       = core.int2 + ((core.int1 - fb) >>> 1);
		next_core = core;
		// Latch pin passes three flops, overload pin and the quiet link word two each
		next_core.lat_s1 = latch_strobe;
		next_core.lat_s2 = core.lat_s1;
		next_core.lat_s3 = core.lat_s2;
		next_core.ovl_s1 = ref_overload;
		next_core.ovl_s2 = core.ovl_s1;
		next_core.lkw_s1 = lk;
		next_core.lkw_s2 = core.lkw_s1;
		next_core.latch_pulse = 1'h0;
		// count restarts at each latch rise
		if (rise) begin
			next_core.base = core.lkw_s2.cnt;
		end
		if (take) begin
			next_core.latch_pulse   = 1'h1;
			next_core.setting.alarm = pulses > ldsl_pkg::NORMAL_MAX;
			if (pulses > ldsl_pkg::NORMAL_MAX) begin
				next_core.setting.word  = core.lkw_s2.shreg;
				next_core.setting.level = core.lkw_s2.shreg;
			end else begin
				// lower 16 bits, offset by 4 mA
				next_core.setting.word  = {1'h0, core.lkw_s2.shreg[NW-1:0]};
				next_core.setting.level = ldsl_pkg::NORM_BASE + {1'h0, core.lkw_s2.shreg[NW-1:0]};
			end
		end
		case (core.run)
			ldsl_pkg::LDSL_RUN: begin
				next_core.int1    = i1n;
				next_core.int2    = i2n;
				next_core.mod_bit = ~i2n[AW-1];
				if (core.ovl_s2) begin
					next_core.run = ldsl_pkg::LDSL_HALT;
				end
			end
			ldsl_pkg::LDSL_HALT: begin
				if (!core.ovl_s2) begin
					next_core.run = ldsl_pkg::LDSL_RUN;
				end
			end
			default: begin
				next_core.run = ldsl_pkg::LDSL_HALT;
			end
		endcase
		// overload acts as an internal power-on reset
		if (core.ovl_s2) begin
			next_core.setting     = '{alarm: 1'h0, word: ldsl_pkg::WORD_RST, level: ldsl_pkg::WORD_RST};
			next_core.int1        = $signed(ldsl_pkg::ACC_RST);
			next_core.int2        = $signed(ldsl_pkg::ACC_RST);
			next_core.mod_bit     = 1'h0;
			next_core.latch_pulse = 1'h0;
		end
	end

	// latch changes only on a taken rise or under overload
	assign rise   = core.lat_s2 & ~core.lat_s3;
	assign pulses = core.lkw_s2.cnt - core.base;
	assign take   = rise && !core.ovl_s2 && core.run == ldsl_pkg::LDSL_RUN;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core.run         <= ldsl_pkg::LDSL_HALT;
			// Syncs rest at the idle high level of the latch line, so release shows no rise
			core.lat_s1      <= 1'h1;
			core.lat_s2      <= 1'h1;
			core.lat_s3      <= 1'h1;
			core.ovl_s1      <= 1'h0;
			core.ovl_s2      <= 1'h0;
			core.lkw_s1      <= '{shreg: ldsl_pkg::WORD_RST, cnt: ldsl_pkg::CNT_RST};
			core.lkw_s2      <= '{shreg: ldsl_pkg::WORD_RST, cnt: ldsl_pkg::CNT_RST};
			core.base        <= ldsl_pkg::CNT_RST;
			core.setting     <= '{alarm: 1'h0, word: ldsl_pkg::WORD_RST, level: ldsl_pkg::WORD_RST};
			core.latch_pulse <= 1'h0;
			core.int1        <= $signed(ldsl_pkg::ACC_RST);
			core.int2        <= $signed(ldsl_pkg::ACC_RST);
			core.mod_bit     <= 1'h0;
		end else begin
			core <= next_core;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign setting     = core.setting;
	assign latch_pulse = core.latch_pulse;
	assign mod_bit     = core.mod_bit;
	assign mod_enable  = core.run == ldsl_pkg::LDSL_RUN;
	// Oscillator shares the run state: both stop under overload
	assign osc_run     = core.run == ldsl_pkg::LDSL_RUN;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_shift_msb_first;
		@(posedge serial_clk) disable iff (!rstn)
		1 |=> lk.shreg == {$past(lk.shreg[SW-2:0]), $past(serial_data)};
	endproperty
	a_shift_msb_first: assert property (p_shift_msb_first) else $error("shift register did not take data");

	property p_count_step;
		@(posedge serial_clk) disable iff (!rstn)
		1 |=> lk.cnt == $past(lk.cnt) + ldsl_pkg::CNT_STEP;
	endproperty
	a_count_step: assert property (p_count_step) else $error("pulse counter did not advance");

	// ----------------------------------------------------------------
	// Link domain: depth of the shift register; core domain: latch capture, range and hold
	// ----------------------------------------------------------------
	property p_shift_depth;
		@(posedge serial_clk) disable iff (!rstn)
		1 |=> lk.shreg[SW-1] == $past(lk.shreg[SW-2]);
	endproperty
	a_shift_depth: assert property (p_shift_depth) else $error("top bit not taken from the place below");

	property p_keep_last;
		@(posedge serial_clk) disable iff (!rstn)
		1 |=> lk.shreg[SW-1:1] == $past(lk.shreg[SW-2:0]);
	endproperty
	a_keep_last: assert property (p_keep_last) else $error("shift register lost one of the last bits");

	property p_capture;
		@(posedge clk) disable iff (!rstn)
		take |=> latch_pulse ##1 !latch_pulse;
	endproperty
	a_capture: assert property (p_capture) else $error("latch rise not taken for one cycle");

	property p_mode;
		@(posedge clk) disable iff (!rstn)
		take |=> setting.alarm == ($past(pulses) > ldsl_pkg::NORMAL_MAX);
	endproperty
	a_mode: assert property (p_mode) else $error("wrong range chosen from pulse count");

	property p_normal_word;
		@(posedge clk) disable iff (!rstn)
		take && pulses <= ldsl_pkg::NORMAL_MAX |=> setting.word == {1'h0, $past(core.lkw_s2.shreg[NW-1:0])};
	endproperty
	a_normal_word: assert property (p_normal_word) else $error("normal word not the lower bits");

	property p_normal_level;
		@(posedge clk) disable iff (!rstn)
		latch_pulse && !setting.alarm |-> setting.level == ldsl_pkg::NORM_BASE + setting.word;
	endproperty
	a_normal_level: assert property (p_normal_level) else $error("normal level not offset by 4 mA");

	property p_alarm_word;
		@(posedge clk) disable iff (!rstn)
		take && pulses > ldsl_pkg::NORMAL_MAX |=> setting.word == $past(core.lkw_s2.shreg) && setting.level == setting.word;
	endproperty
	a_alarm_word: assert property (p_alarm_word) else $error("alarm word not the last 17 bits");

	property p_overload;
		@(posedge clk) disable iff (!rstn)
		core.ovl_s2 |=> setting.word == ldsl_pkg::WORD_RST && !setting.alarm && !mod_enable && !osc_run && !mod_bit;
	endproperty
	a_overload: assert property (p_overload) else $error("overload did not clear and stop");

	property p_hold;
		@(posedge clk) disable iff (!rstn)
		!take && !core.ovl_s2 |=> $stable(setting);
	endproperty
	a_hold: assert property (p_hold) else $error("latch changed without a latch rise");

	property p_restart;
		@(posedge clk) disable iff (!rstn)
		rise |=> core.base == $past(core.lkw_s2.cnt);
	endproperty
	a_restart: assert property (p_restart) else $error("pulse count not restarted at latch rise");

	property p_mod_quiet;
		@(posedge clk) disable iff (!rstn)
		!mod_enable |=> !mod_bit;
	endproperty
	a_mod_quiet: assert property (p_mod_quiet) else $error("modulator ran while disabled");

	// ----------------------------------------------------------------
	// Core domain: range, halt and modulator details
	// ----------------------------------------------------------------
	property p_alarm_msb;
		@(posedge clk) disable iff (!rstn)
		take && pulses > ldsl_pkg::NORMAL_MAX |=> setting.word[SW-1] == $past(core.lkw_s2.shreg[SW-1]);
	endproperty
	a_alarm_msb: assert property (p_alarm_msb) else $error("alarm word top bit not the oldest kept bit");

	property p_normal_range;
		@(posedge clk) disable iff (!rstn)
		take && pulses <= ldsl_pkg::NORMAL_MAX |=> !setting.alarm && !setting.word[SW-1];
	endproperty
	a_normal_range: assert property (p_normal_range) else $error("normal write set the alarm bit");

	property p_normal_span;
		@(posedge clk) disable iff (!rstn)
		latch_pulse && !setting.alarm |-> setting.level >= ldsl_pkg::NORM_BASE;
	endproperty
	a_normal_span: assert property (p_normal_span) else $error("normal level below 4 mA");

	property p_alarm_level;
		@(posedge clk) disable iff (!rstn)
		setting.alarm |-> setting.level == setting.word;
	endproperty
	a_alarm_level: assert property (p_alarm_level) else $error("alarm level not the word itself");

	property p_pulse_source;
		@(posedge clk) disable iff (!rstn)
		latch_pulse |-> $past(take);
	endproperty
	a_pulse_source: assert property (p_pulse_source) else $error("latch pulse without a taken rise");

	property p_count_zero;
		@(posedge clk) disable iff (!rstn)
		rise |=> pulses == ldsl_pkg::CNT_RST;
	endproperty
	a_count_zero: assert property (p_count_zero) else $error("pulse count not zero after latch rise");

	property p_halt_refuses;
		@(posedge clk) disable iff (!rstn)
		!mod_enable && rise |=> !latch_pulse && $stable(setting);
	endproperty
	a_halt_refuses: assert property (p_halt_refuses) else $error("latch strobe taken while halted");

	property p_resume;
		@(posedge clk) disable iff (!rstn)
		!mod_enable && !core.ovl_s2 |=> mod_enable;
	endproperty
	a_resume: assert property (p_resume) else $error("modulator did not restart after overload");

	property p_mod_idle;
		@(posedge clk) disable iff (!rstn)
		!mod_enable |-> core.int1 == ldsl_pkg::ACC_RST && core.int2 == ldsl_pkg::ACC_RST;
	endproperty
	a_mod_idle: assert property (p_mod_idle) else $error("integrators not cleared while halted");

	property p_mod_sign;
		@(posedge clk) disable iff (!rstn)
		mod_enable && !core.ovl_s2 |=> mod_bit == !core.int2[AW-1];
	endproperty
	a_mod_sign: assert property (p_mod_sign) else $error("stream bit not the sign of the second integrator");

	c_normal_write: cover property (@(posedge clk) disable iff (!rstn) latch_pulse && !setting.alarm);
	c_alarm_write: cover property (@(posedge clk) disable iff (!rstn) latch_pulse && setting.alarm);
	c_byte_triple: cover property (@(posedge clk) disable iff (!rstn) take && pulses == 5'h18);
	c_overload: cover property (@(posedge clk) disable iff (!rstn) mod_enable ##1 !mod_enable);
	c_halted_strobe: cover property (@(posedge clk) disable iff (!rstn) !mod_enable && rise);

endmodule : ldsl_loader

`default_nettype wire

// *** bench/ldsl_host.sv ***
// Host model: drives the three-wire link of the loader in framed writes
`timescale 1ns/100ps
`default_nettype none

module ldsl_host (
	output var logic serial_clk,
	output var logic serial_data,
	output var logic latch_strobe
);
	logic tick;
	logic framing;

	// Link base clock, 12 ns, phase unrelated to the core clock
	initial begin
		tick = 1'b0;
		#3.3;
		forever #6 tick = ~tick;
	end

	initial begin
		serial_clk   = 1'b0;
		serial_data  = 1'b0;
		latch_strobe = 1'b1;
		framing      = 1'b0;
	end

	// Undriven data keeps moving so a stale bit can never look valid
	always @(posedge tick) begin
		if (!framing) serial_data <= ~serial_data;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge tick);
	endtask : ticks

	// latch low, MSB first, 108 ns bit time, latch last
	task automatic write(input logic [47:0] bits, input int n, input bit commit);
		ticks(1);
		framing      = 1'b1;
		latch_strobe = 1'b0;
		ticks(8);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data = bits[i];
			ticks(5);
			serial_clk = 1'b1;
			ticks(4);
			serial_clk = 1'b0;
		end
		framing = 1'b0;
		ticks(4);
		if (commit) latch_strobe = 1'b1;
	endtask : write

	// Keeps the strobe high well past three core cycles
	task automatic hold();
		ticks(12);
	endtask : hold
endmodule : ldsl_host

`default_nettype wire

// *** bench/tb_loop_dac_serial_loader.sv ***
// Self-checking bench of the serial loader against a host model
`timescale 1ns/100ps
`default_nettype none

module tb_loop_dac_serial_loader;
	logic                    clk;
	logic                    rstn;
	logic                    ref_overload;
	logic                    serial_clk;
	logic                    serial_data;
	logic                    latch_strobe;
	ldsl_pkg::ldsl_setting_t setting;
	logic                    latch_pulse;
	logic                    mod_bit;
	logic                    mod_enable;
	logic                    osc_run;
	int                      n_mismatch = 0;
	int                      total_checks = 0;
	int                      seed = 10;
	int                      cyc = 0;
	int                      cnt = 0;
	bit                      halted = 0;
	logic [16:0]             sh = 17'h00000;
	ldsl_pkg::ldsl_setting_t want = '0;
	int                      lens[12] = '{16, 0, 8, 15, 17, 24, 31, 32, 33, 40, 48, 16};

	ldsl_loader u_ldsl_loader (.clk(clk), .rstn(rstn), .serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe), .ref_overload(ref_overload), .setting(setting),
		.latch_pulse(latch_pulse), .mod_bit(mod_bit), .mod_enable(mod_enable), .osc_run(osc_run));
	ldsl_host u_ldsl_host (.serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Ceiling more than five times the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude

	function automatic ldsl_pkg::ldsl_setting_t expect_of(input logic [16:0] s, input int c);
		if ((c % 32) > 16) return {1'b1, s, s};
		return {1'b0, {1'b0, s[15:0]}, ldsl_pkg::NORM_BASE + {1'b0, s[15:0]}};
	endfunction : expect_of

	function automatic logic [16:0] alarm_code(input logic [16:0] r);
		if (r >= 17'h03800 && r <= 17'h18000) return r;
		return 17'h03800 + r % 17'h14801;
	endfunction : alarm_code

	task automatic put(input logic [47:0] b, input int n, input bit commit);
		int k;
		if (n >= 17 && ((cnt + n) % 32) > 16) b[16:0] = alarm_code(b[16:0]);
		u_ldsl_host.write(b, n, commit);
		for (int i = n - 1; i >= 0; i--) sh = {sh[15:0], b[i]};
		cnt += n;
		if (!commit) return;
		k = 0;
		// A pulse must show within a dozen core cycles of the strobe
		while (latch_pulse !== 1'b1 && k < 12) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (!halted) want = expect_of(sh, cnt);
		check(latch_pulse, !halted);
		check(setting, want);
		u_ldsl_host.hold();
		cnt = 0;
	endtask : put

	task automatic ovl(input logic v);
		@(negedge clk);
		ref_overload = v;
		halted       = v;
		repeat (5) @(negedge clk);
		if (v) want = '0;
		check({setting, mod_enable, osc_run, mod_bit & v}, {want, !v, !v, 1'b0});
	endtask : ovl

	initial begin : main
		int ones;
		int lvl;
		rstn         = 1'b0;
		ref_overload = 1'b0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		check({setting, mod_enable}, {35'h0, 1'b1});
		put({$random(seed), $random(seed)}, 24, 1);
		put(48'h0, 16, 1);
		put(48'hFFFF, 16, 1);
		put(48'h0FFFF, 17, 1);
		foreach (lens[i]) put({$random(seed), $random(seed)}, lens[i], 1);
		// Clocks without a strobe must leave the latch alone
		// leading 00100 keeps the split alarm code in range
		put(48'h04, 5, 0);
		repeat (20) begin
			@(posedge clk);
			#1;
			check({setting, latch_pulse}, {want, 1'b0});
		end
		put({$random(seed), $random(seed)}, 12, 1);
		put(48'h0C000, 16, 1);
		// Ones density of the stream follows the level on the 17-bit scale
		repeat (64) @(posedge clk);
		ones = 0;
		repeat (2048) begin
			@(posedge clk);
			#1;
			ones += int'(mod_bit);
		end
		lvl = int'(setting.level) >> 6;
		check((ones - lvl <= 16) && (lvl - ones <= 16), 1'b1);
		ovl(1'b1);
		put({$random(seed), $random(seed)}, 16, 1);
		check({setting, mod_enable}, {35'h0, 1'b0});
		ovl(1'b0);
		put({$random(seed), $random(seed)}, 24, 1);
		put({$random(seed), $random(seed)}, 16, 1);
		conclude();
	end
endmodule : tb_loop_dac_serial_loader

`default_nettype wire
